/* File: cic_defs.svh */
// Constants of the cascaded interrupt controller: offsets, fields, reset values
// Notes on behaviour
// - Master and slave, eight maskable inputs each
// - At most fifteen requests served at once
// - Eighteen sources reach inputs through multiplexers
// - Master nine sources, slave nine, input 1 shared
// - Slave output feeds master request input 2
// - Forward only enabled requests of sufficient priority
// - Only the requested controller drives the vector
// - Master gives three-bit cascade code at acknowledge
// - Six pins feed master only, slaves allowed
// - High pin pair muxed against serial requests
// - Pin six and DMA done swap on slave
// - Config bit 7 puts cascade on address
// - Cascade lines high between pulses; latch outside
// - Config registers select pin request sources
`ifndef CIC_DEFS_SVH
`define CIC_DEFS_SVH

// Register offsets on the plain register port
`define CIC_OFS_INTR_CFG 4'h0
`define CIC_OFS_PORT3_CFG 4'h1
`define CIC_OFS_M_MASK 4'h2
`define CIC_OFS_S_MASK 4'h3
`define CIC_OFS_CONTROL 4'h4
`define CIC_OFS_M_VEC 4'h5
`define CIC_OFS_S_VEC 4'h6
`define CIC_OFS_M_INSVC 4'h7
`define CIC_OFS_S_INSVC 4'h8
`define CIC_OFS_EVT_STAT 4'h9
`define CIC_OFS_EVT_MASK 4'hA
`define CIC_OFS_CAS_MAP 4'hB

// Control register fields
`define CIC_CTL_GLOBAL_EN 0
`define CIC_CTL_M_EOI 1
`define CIC_CTL_S_EOI 2

// Event status fields
`define CIC_EVT_REQ 0
`define CIC_EVT_ACK 1
`define CIC_EVT_SPUR 2

// Interrupt configuration fields
`define CIC_CFG_CAS_ON_ADDR 7
`define CIC_CFG_INT9_SEL 5
`define CIC_CFG_INT8_SEL 6
`define CIC_CFG_SWAP 4
`define CIC_CFG_INT7_EN 3
`define CIC_CFG_EXT_IRQ_SIX_EN 2
`define CIC_CFG_INT5_SEL 1
`define CIC_CFG_INT4_EN 0

// Reset values and fixed codes
`define CIC_RST_MASK 8'hFF
`define CIC_RST_ZERO 8'h00
`define CIC_RST_CAS_MAP 8'h04
`define CIC_SLAVE_INDEX 3'h2
`define CIC_CAS_IDLE 3'h7

`endif

/* File: cic_pkg.sv */
// Types shared by the cascaded interrupt controller modules
`default_nettype none
package cic_pkg;
   // One byte of register data
   typedef logic [7:0] cic_byte_t;
   // Acknowledge sequence, one-hot
   typedef enum logic [3:0] {
      ACK_IDLE = 4'b0001,
      ACK_FIRST = 4'b0010,
      ACK_GAP = 4'b0100,
      ACK_SECOND = 4'b1000
   } cic_ack_t;
   // Vector source chosen at the first pulse
   typedef enum logic [1:0] {
      VEC_NONE = 2'b00,
      VEC_MASTER = 2'b01,
      VEC_SLAVE = 2'b10
   } cic_vsrc_t;
   // State of one controller
   typedef struct packed {
      logic [7:0] inSvc;
      logic [2:0] level;
   } cic_ctrl_t;
   // State of the top block
   typedef struct packed {
      cic_byte_t intrCfg;
      cic_byte_t port3Cfg;
      cic_byte_t mMask;
      cic_byte_t sMask;
      logic globalEn;
      cic_byte_t mVec;
      cic_byte_t sVec;
      cic_byte_t casMap;
      logic [2:0] evtStat;
      logic [2:0] evtMask;
      cic_ack_t ack;
      logic ackPrev;
      logic mIntPrev;
      logic [2:0] casCode;
      cic_vsrc_t vsrc;
      cic_byte_t vecData;
      cic_byte_t rdData;
   } cic_top_t;
endpackage : cic_pkg
`default_nettype wire

/* File: cic_ctrl.sv */
// One interrupt controller: masking, nested priority, in-service tracking
`include "cic_defs.svh"
`default_nettype none
module cic_ctrl #(
   parameter int N = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Requests and masking
   input wire logic [N-1:0] reqIn,
   input wire logic [N-1:0] maskBits,
   input wire logic enable,
   input wire logic [N-1:0] equalPass,
   // Acknowledge and end of service
   input wire logic freeze,
   input wire logic eoi,
   // Results
   output logic intOut,
   output logic [2:0] winLevel,
   output logic winValid,
   output logic [2:0] frozenLevel,
   output logic [N-1:0] inService
);
   import cic_pkg::*;

   cic_ctrl_t st_r;
   cic_ctrl_t st_nxt;
   logic [N-1:0] elig; // Enabled, unmasked requests
   logic topSvcValid;
   logic [2:0] topSvc; // Highest level in service

   // Per-input eligibility
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gElig
         assign elig[g] = reqIn[g] & ~maskBits[g] & enable;
      end
   endgenerate

   // Lowest index wins; in-service levels block equal and lower ones
   always_comb begin
      winValid = 1'b0;
      winLevel = 3'h0;
      topSvcValid = 1'b0;
      topSvc = 3'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (elig[i]) begin
            winValid = 1'b1;
            winLevel = 3'(i);
         end
         if (st_r.inSvc[i]) begin
            topSvcValid = 1'b1;
            topSvc = 3'(i);
         end
      end
      // Cascaded inputs may re-enter at equal level so a higher slave source gets through
      intOut = winValid && (!topSvcValid || winLevel < topSvc ||
                            (winLevel == topSvc && equalPass[winLevel]));
   end

   // Next state: end of service first, so a same-cycle freeze still sets its bit
   always_comb begin
      st_nxt = st_r;
      if (eoi && topSvcValid) begin
         st_nxt.inSvc[topSvc] = 1'b0;
      end
      if (freeze) begin
         // No winner: report the lowest level, nothing enters service
         st_nxt.level = winValid ? winLevel : 3'h7;
         if (winValid) begin
            st_nxt.inSvc[winLevel] = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign frozenLevel = st_r.level;
   assign inService = st_r.inSvc;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Disabled or masked work never reaches the output
   fwdNeedsEnable_a: assert property (intOut |-> enable && (reqIn & ~maskBits) != '0)
      else $error("request forwarded while disabled or masked");
   // A frozen winner is in service on the next cycle
   isrOnFreeze_a: assert property (freeze && winValid && !eoi |=> inService[$past(winLevel)])
      else $error("frozen winner not in service");
   // Global disable silences the controller
   globalOff_a: assert property (!enable |-> !intOut && !winValid)
      else $error("output while globally disabled");
endmodule // cic_ctrl
`default_nettype wire

/* File: cic_top.sv */
// Cascaded interrupt controller pair with source muxing, acknowledge and registers
//
// Implementation choices: the strobed register port and the address map.
`include "cic_defs.svh"
`default_nettype none
module cic_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire logic [3:0] regAddr,
   input wire cic_pkg::cic_byte_t regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output cic_pkg::cic_byte_t regRdata,
   // Internal peripheral requests
   input wire logic timer0Irq,
   input wire logic timer1Irq,
   input wire logic timer2Irq,
   input wire logic asyncSerial0Irq,
   input wire logic asyncSerial1Irq,
   input wire logic syncSerialIrq,
   input wire logic dmaDoneIrq,
   input wire logic watchdogIrq,
   // External request pins
   input wire logic [3:0] extIrqLowGroup,
   input wire logic [1:0] extIrqHighPair,
   input wire logic extIrqFour,
   input wire logic extIrqFive,
   input wire logic extIrqSix,
   input wire logic extIrqSeven,
   // Core side
   output logic coreIntr,
   input wire logic intrAckStrobe_n,
   output logic [2:0] cascadeSelect,
   output cic_pkg::cic_byte_t vectorData,
   output logic vectorOe,
   // Cascade code on upper address lines
   output logic [2:0] upperAddrLines,
   output logic upperAddrOe,
   // Interrupt to system
   output logic irq
);
   import cic_pkg::*;

   cic_top_t st_r;
   cic_top_t st_nxt;
   logic [7:0] mReq; // Master request inputs after muxing
   logic [7:0] sReq; // Slave request inputs after muxing
   logic [7:0] casMapEff; // Master inputs that carry a slave
   logic mInt, sInt; // Forwarded requests
   logic mWinValid, sWinValid;
   logic [2:0] mWin, sWin;
   logic [2:0] mFrozen, sFrozen;
   logic [7:0] mInSvc, sInSvc;
   logic freezeM, freezeS; // First-pulse strobes
   logic mEoi, sEoi; // End-of-service strobes
   logic ackFall, ackRise; // Strobe edges
   logic [2:0] evtSet, evtClr;

   // Internal slave always sits on input 2
   assign casMapEff = st_r.casMap | `CIC_RST_CAS_MAP;

   // Master source selection; disconnected inputs read as ground
   always_comb begin
      mReq[0] = timer0Irq;
      mReq[1] = st_r.port3Cfg[2] & extIrqLowGroup[0];
      mReq[2] = sInt;
      // High pair only when both config bits pick the pin
      mReq[3] = (st_r.intrCfg[`CIC_CFG_INT8_SEL] && st_r.port3Cfg[1]) ? extIrqHighPair[0] : asyncSerial1Irq;
      mReq[4] = (st_r.intrCfg[`CIC_CFG_INT9_SEL] && st_r.port3Cfg[0]) ? extIrqHighPair[1] : asyncSerial0Irq;
      mReq[5] = st_r.port3Cfg[3] & extIrqLowGroup[1];
      mReq[6] = st_r.port3Cfg[4] & extIrqLowGroup[2];
      mReq[7] = st_r.port3Cfg[5] & extIrqLowGroup[3];
   end

   // Slave source selection, nine sources with input 1 shared
   always_comb begin
      sReq[0] = st_r.intrCfg[`CIC_CFG_INT4_EN] & extIrqFour;
      sReq[1] = st_r.intrCfg[`CIC_CFG_INT5_SEL] ? extIrqFive : syncSerialIrq;
      sReq[2] = timer1Irq;
      sReq[3] = timer2Irq;
      // Swap of pin six and DMA done
      sReq[4] = st_r.intrCfg[`CIC_CFG_SWAP] ? extIrqSix : dmaDoneIrq;
      sReq[5] = st_r.intrCfg[`CIC_CFG_EXT_IRQ_SIX_EN] &
                (st_r.intrCfg[`CIC_CFG_SWAP] ? dmaDoneIrq : extIrqSix);
      sReq[6] = st_r.intrCfg[`CIC_CFG_INT7_EN] & extIrqSeven;
      sReq[7] = watchdogIrq;
   end

   // Slave controller, plain fully nested
   cic_ctrl #(.N(8)) uSlave (
      .clk(clk),
      .rst_b(rst_b),
      .reqIn(sReq),
      .maskBits(st_r.sMask),
      .enable(st_r.globalEn),
      .equalPass(8'h00),
      .freeze(freezeS),
      .eoi(sEoi),
      .intOut(sInt),
      .winLevel(sWin),
      .winValid(sWinValid),
      .frozenLevel(sFrozen),
      .inService(sInSvc)
   );

   // Master controller, special nesting on cascaded inputs
   cic_ctrl #(.N(8)) uMaster (
      .clk(clk),
      .rst_b(rst_b),
      .reqIn(mReq),
      .maskBits(st_r.mMask),
      .enable(st_r.globalEn),
      .equalPass(casMapEff),
      .freeze(freezeM),
      .eoi(mEoi),
      .intOut(mInt),
      .winLevel(mWin),
      .winValid(mWinValid),
      .frozenLevel(mFrozen),
      .inService(mInSvc)
   );

   // Strobe edges against the previous sample
   assign ackFall = !intrAckStrobe_n && st_r.ackPrev;
   assign ackRise = intrAckStrobe_n && !st_r.ackPrev;

   // Next state: registers, acknowledge sequence, events
   always_comb begin
      st_nxt = st_r;
      mEoi = 1'b0;
      sEoi = 1'b0;
      freezeM = 1'b0;
      freezeS = 1'b0;
      evtSet = 3'h0;
      evtClr = 3'h0;
      st_nxt.ackPrev = intrAckStrobe_n;
      st_nxt.mIntPrev = mInt;
      st_nxt.rdData = `CIC_RST_ZERO;
      // Register writes
      if (regWrite) begin
         case (regAddr)
            `CIC_OFS_INTR_CFG: st_nxt.intrCfg = regWdata;
            `CIC_OFS_PORT3_CFG: st_nxt.port3Cfg = regWdata;
            `CIC_OFS_M_MASK: st_nxt.mMask = regWdata;
            `CIC_OFS_S_MASK: st_nxt.sMask = regWdata;
            `CIC_OFS_CONTROL: begin
               st_nxt.globalEn = regWdata[`CIC_CTL_GLOBAL_EN];
               mEoi = regWdata[`CIC_CTL_M_EOI];
               sEoi = regWdata[`CIC_CTL_S_EOI];
            end
            `CIC_OFS_M_VEC: st_nxt.mVec = regWdata;
            `CIC_OFS_S_VEC: st_nxt.sVec = regWdata;
            `CIC_OFS_EVT_STAT: evtClr = regWdata[2:0];
            `CIC_OFS_EVT_MASK: st_nxt.evtMask = regWdata[2:0];
            `CIC_OFS_CAS_MAP: st_nxt.casMap = regWdata;
            default: ;
         endcase
      end
      // Register reads, data in the following cycle
      if (regRead) begin
         case (regAddr)
            `CIC_OFS_INTR_CFG: st_nxt.rdData = st_r.intrCfg;
            `CIC_OFS_PORT3_CFG: st_nxt.rdData = st_r.port3Cfg;
            `CIC_OFS_M_MASK: st_nxt.rdData = st_r.mMask;
            `CIC_OFS_S_MASK: st_nxt.rdData = st_r.sMask;
            `CIC_OFS_CONTROL: st_nxt.rdData = {7'h00, st_r.globalEn};
            `CIC_OFS_M_VEC: st_nxt.rdData = st_r.mVec;
            `CIC_OFS_S_VEC: st_nxt.rdData = st_r.sVec;
            `CIC_OFS_M_INSVC: st_nxt.rdData = mInSvc;
            `CIC_OFS_S_INSVC: st_nxt.rdData = sInSvc;
            `CIC_OFS_EVT_STAT: st_nxt.rdData = {5'h00, st_r.evtStat};
            `CIC_OFS_EVT_MASK: st_nxt.rdData = {5'h00, st_r.evtMask};
            `CIC_OFS_CAS_MAP: st_nxt.rdData = casMapEff;
            default: st_nxt.rdData = `CIC_RST_ZERO;
         endcase
      end
      // New forwarded request to the core
      evtSet[`CIC_EVT_REQ] = mInt && !st_r.mIntPrev;
      // Acknowledge sequence driven by the core's two pulses
      case (st_r.ack)
         ACK_IDLE: begin
            if (ackFall) begin
               freezeM = 1'b1;
               st_nxt.ack = ACK_FIRST;
               evtSet[`CIC_EVT_SPUR] = !mWinValid;
               if (mWinValid && casMapEff[mWin]) begin
                  st_nxt.casCode = mWin;
                  if (mWin == `CIC_SLAVE_INDEX) begin
                     freezeS = 1'b1;
                     st_nxt.vsrc = VEC_SLAVE;
                  end else begin
                     // External slave supplies its own vector
                     st_nxt.vsrc = VEC_NONE;
                  end
               end else begin
                  st_nxt.casCode = 3'h0;
                  st_nxt.vsrc = VEC_MASTER;
               end
            end
         end
         ACK_FIRST: begin
            if (ackRise) begin
               st_nxt.ack = ACK_GAP;
            end
         end
         ACK_GAP: begin
            if (ackFall) begin
               st_nxt.ack = ACK_SECOND;
               // Only the acknowledged controller's byte is prepared
               case (st_r.vsrc)
                  VEC_MASTER: st_nxt.vecData = {st_r.mVec[7:3], mFrozen};
                  VEC_SLAVE: st_nxt.vecData = {st_r.sVec[7:3], sFrozen};
                  default: st_nxt.vecData = `CIC_RST_ZERO;
               endcase
            end
         end
         ACK_SECOND: begin
            if (ackRise) begin
               st_nxt.ack = ACK_IDLE;
               evtSet[`CIC_EVT_ACK] = 1'b1;
            end
         end
         default: st_nxt.ack = ACK_IDLE;
      endcase
      // Sticky events: a new event beats a same-cycle clear
      st_nxt.evtStat = (st_r.evtStat & ~evtClr) | evtSet;
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r.intrCfg <= `CIC_RST_ZERO;
         st_r.port3Cfg <= `CIC_RST_ZERO;
         st_r.mMask <= `CIC_RST_MASK;
         st_r.sMask <= `CIC_RST_MASK;
         st_r.globalEn <= 1'b0;
         st_r.mVec <= `CIC_RST_ZERO;
         st_r.sVec <= `CIC_RST_ZERO;
         st_r.casMap <= `CIC_RST_CAS_MAP;
         st_r.evtStat <= 3'h0;
         st_r.evtMask <= 3'h0;
         st_r.ack <= ACK_IDLE;
         st_r.ackPrev <= 1'b1;
         st_r.mIntPrev <= 1'b0;
         st_r.casCode <= 3'h0;
         st_r.vsrc <= VEC_NONE;
         st_r.vecData <= `CIC_RST_ZERO;
         st_r.rdData <= `CIC_RST_ZERO;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign regRdata = st_r.rdData;
   assign coreIntr = mInt;
   // Code valid during pulses, high in between; outside slaves must latch it
   assign cascadeSelect = (st_r.ack == ACK_FIRST || st_r.ack == ACK_SECOND) ? st_r.casCode : `CIC_CAS_IDLE;
   assign upperAddrLines = cascadeSelect;
   assign upperAddrOe = st_r.intrCfg[`CIC_CFG_CAS_ON_ADDR];
   assign vectorData = st_r.vecData;
   // Bus left undriven except while the second pulse stands
   assign vectorOe = (st_r.ack == ACK_SECOND) && (st_r.vsrc != VEC_NONE);
   assign irq = |(st_r.evtStat & st_r.evtMask);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Slave output lands on master input 2
   slaveOnIr2_a: assert property (mReq[2] == sInt)
      else $error("slave request not on master input 2");
   // Lines high in the gap between pulses
   casGapHigh_a: assert property (st_r.ack == ACK_GAP |-> cascadeSelect == 3'h7)
      else $error("cascade not high between pulses");
   // Vector drive only in the second pulse; a slow rise still sees the strobe low one sample back
   vecSecondOnly_a: assert property (vectorOe |-> st_r.ack == ACK_SECOND && !$past(intrAckStrobe_n))
      else $error("vector driven outside second pulse");
   // Cascaded winner shows its code during the first pulse
   casCodeShown_a: assert property (st_r.ack == ACK_IDLE && ackFall && mWinValid && casMapEff[mWin]
                                    |=> cascadeSelect == $past(mWin))
      else $error("cascade code wrong in first pulse");
   // External slave gets no vector from this block
   extNoVector_a: assert property (st_r.vsrc == VEC_NONE |-> !vectorOe)
      else $error("vector driven for external slave");
   // Address lines follow config bit and cascade
   addrMirror_a: assert property (upperAddrOe == st_r.intrCfg[7] && upperAddrLines == cascadeSelect)
      else $error("upper address cascade mismatch");
   // Swap bit exchanges pin six and DMA done on input 4
   swapMux_a: assert property (sReq[4] == (st_r.intrCfg[4] ? extIrqSix : dmaDoneIrq))
      else $error("slave input 4 source wrong");
   // Serial request used unless both bits pick the pin
   highPairMux_a: assert property (!(st_r.intrCfg[6] && st_r.port3Cfg[1]) |-> mReq[3] == asyncSerial1Irq)
      else $error("master input 3 source wrong");

   // Main scenarios
   ackMaster_c: cover property (st_r.ack == ACK_SECOND && st_r.vsrc == VEC_MASTER && vectorOe);
   ackSlave_c: cover property (st_r.ack == ACK_SECOND && st_r.vsrc == VEC_SLAVE && vectorOe);
   ackExternal_c: cover property (st_r.ack == ACK_FIRST && st_r.vsrc == VEC_NONE && upperAddrOe);
endmodule // cic_top
`default_nettype wire

/* File: cic_core_model.sv */
// Behavioural core: answers forwarded requests with a two-pulse acknowledge
`default_nettype none
module cic_core_model (
   // Clock
   input wire logic clk,
   // Request and acknowledge
   input wire logic coreIntr,
   output var logic intrAckStrobe_n,
   // Vector and cascade observation
   input wire cic_pkg::cic_byte_t vectorData,
   input wire logic vectorOe,
   input wire logic [2:0] cascadeSelect,
   input wire logic [2:0] upperAddrLines
);
   timeunit 1ns;
   timeprecision 1ps;
   import cic_pkg::*;
   // Vector and code taken while the block drives the bus
   cic_byte_t lastVec = 8'h00;
   logic [2:0] lastCas = 3'h7;
   // Code and address lines seen at the edge of the second fall
   logic [2:0] midCas = 3'h7;
   logic [2:0] midAddr = 3'h7;
   // Vector cycles, and those outside the second pulse
   int oeCount = 0;
   int oeEarly = 0;
   // Acknowledges that found no request in time
   int waitOut = 0;
   logic second = 1'b0;

   // Strobe idles high
   initial intrAckStrobe_n = 1'b1;

   // The data bus means nothing unless enabled, so only then is it read
   always @(posedge clk) begin
      if (vectorOe === 1'b1) begin
         lastVec <= vectorData;
         lastCas <= cascadeSelect;
         oeCount <= oeCount + 1;
         if (!second) begin
            oeEarly <= oeEarly + 1;
         end
      end
   end

   // Two low pulses, each level held hold cycles; a hold of 2 shows the gap
   task automatic ack(input int hold);
      int w;
      int i;
      // Acknowledge after a forwarded request, or anyway once 50 cycles pass without one
      for (w = 0; w < 50 && coreIntr !== 1'b1; w++) @(posedge clk);
      // A timed-out wait is counted; the bench checks how many it expects
      if (w == 50) begin
         waitOut <= waitOut + 1;
      end
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         if (i == 1) begin
            midCas <= cascadeSelect;
            midAddr <= upperAddrLines;
            second <= 1'b1;
         end
         intrAckStrobe_n <= 1'b0;
         repeat (hold) @(posedge clk);
         intrAckStrobe_n <= 1'b1;
         repeat (hold - 1) @(posedge clk);
      end
      // Let the vector drop before the next request
      repeat (3) @(posedge clk);
      second <= 1'b0;
   endtask
endmodule // cic_core_model
`default_nettype wire

/* File: cic_top_tb.sv */
// Self-checking bench for the cascaded interrupt controller pair
`default_nettype none
module cic_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cic_pkg::*;
   // Clock, reset and register port
   logic clk, rst_b, regWrite, regRead;
   logic [3:0] regAddr;
   cic_byte_t regWdata, regRdata, vectorData;
   // Every request source, one bit each
   logic [17:0] src;
   // Core side
   logic coreIntr, intrAckStrobe_n, vectorOe, upperAddrOe, irq;
   logic [2:0] cascadeSelect, upperAddrLines;
   // Counters
   int n_errors = 0;
   int n_checks = 0;
   int a;

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   cic_top cic_top_inst (
      .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata), .timer0Irq(src[0]), .timer1Irq(src[1]), .timer2Irq(src[2]),
      .asyncSerial0Irq(src[3]), .asyncSerial1Irq(src[4]), .syncSerialIrq(src[5]), .dmaDoneIrq(src[6]),
      .watchdogIrq(src[7]), .extIrqLowGroup(src[11:8]), .extIrqHighPair(src[13:12]), .extIrqFour(src[14]),
      .extIrqFive(src[15]), .extIrqSix(src[16]), .extIrqSeven(src[17]), .coreIntr(coreIntr),
      .intrAckStrobe_n(intrAckStrobe_n), .cascadeSelect(cascadeSelect), .vectorData(vectorData),
      .vectorOe(vectorOe), .upperAddrLines(upperAddrLines), .upperAddrOe(upperAddrOe), .irq(irq)
   );

   cic_core_model cic_core_model_inst (
      .clk(clk), .coreIntr(coreIntr), .intrAckStrobe_n(intrAckStrobe_n), .vectorData(vectorData),
      .vectorOe(vectorOe), .cascadeSelect(cascadeSelect), .upperAddrLines(upperAddrLines)
   );

   // Byte compare; narrow values are zero extended by the caller
   task automatic chk(input cic_byte_t got, input cic_byte_t exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Let registered outputs land
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [3:0] ad, input cic_byte_t d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= ad;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   // One-cycle read strobe; data stand only in the next cycle
   task automatic rd(input logic [3:0] ad, input cic_byte_t exp);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= ad;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(regRdata, exp);
   endtask

   // One source under one routing; acknowledged when a vector is expected
   task automatic tcase(input int s, input cic_byte_t cfg, p3, expV, input logic [2:0] expC);
      wr(4'h0, cfg);
      wr(4'h1, p3);
      @(posedge clk);
      src <= 18'h1 << s;
      settle();
      chk({7'h00, coreIntr}, {7'h00, expV != 8'h00});
      if (expV != 8'h00) begin
         cic_core_model_inst.ack(1);
         chk(cic_core_model_inst.lastVec, expV);
         chk({5'h00, cic_core_model_inst.midCas}, {5'h00, expC});
      end
      @(posedge clk);
      src <= 18'h0;
      wr(4'h4, 8'h07);
   endtask

   // Verdict and end of run
   task automatic final_report();
      $display("Checks %0d, errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs about 500 cycles, this allows 10000
   initial begin
      #400000;
      n_errors++;
      final_report();
   end

   initial begin
      rst_b = 1'b0;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 4'h0;
      regWdata = 8'h00;
      src = 18'h0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      #1 chk({5'h00, cascadeSelect}, 8'h07);
      chk({6'h00, upperAddrOe, irq}, 8'h00);
      // Reset values, then an unmapped index that keeps nothing
      for (a = 0; a < 13; a++) begin
         rd(a[3:0], (a == 2 || a == 3) ? 8'hFF : (a == 11) ? 8'h04 : 8'h00);
      end
      wr(4'hC, 8'hFF);
      rd(4'hC, 8'h00);
      // Quiet while globally off, forwarded once on, quiet again when masked
      wr(4'h2, 8'h00);
      @(posedge clk);
      src <= 18'h1;
      settle();
      chk({7'h00, coreIntr}, 8'h00);
      wr(4'h4, 8'h01);
      settle();
      chk({7'h00, coreIntr}, 8'h01);
      wr(4'h2, 8'h01);
      settle();
      chk({7'h00, coreIntr}, 8'h00);
      src <= 18'h0;
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h00);
      wr(4'h5, 8'h40);
      wr(4'h6, 8'h80);
      // Routing choices of both controllers, except master inputs 5 and 6 and slave input 2
      tcase(0, 8'h00, 8'h00, 8'h40, 3'h0);
      tcase(8, 8'h00, 8'h00, 8'h00, 3'h0);
      tcase(8, 8'h00, 8'h04, 8'h41, 3'h0);
      tcase(4, 8'h00, 8'h00, 8'h43, 3'h0);
      tcase(12, 8'h40, 8'h02, 8'h43, 3'h0);
      tcase(3, 8'h00, 8'h00, 8'h44, 3'h0);
      tcase(13, 8'h20, 8'h01, 8'h44, 3'h0);
      tcase(11, 8'h00, 8'h20, 8'h47, 3'h0);
      tcase(14, 8'h01, 8'h00, 8'h80, 3'h2);
      tcase(5, 8'h00, 8'h00, 8'h81, 3'h2);
      tcase(15, 8'h02, 8'h00, 8'h81, 3'h2);
      tcase(2, 8'h00, 8'h00, 8'h83, 3'h2);
      tcase(6, 8'h00, 8'h00, 8'h84, 3'h2);
      tcase(16, 8'h10, 8'h00, 8'h84, 3'h2);
      tcase(6, 8'h14, 8'h00, 8'h85, 3'h2);
      tcase(16, 8'h04, 8'h00, 8'h85, 3'h2);
      tcase(16, 8'h00, 8'h00, 8'h00, 3'h0);
      tcase(17, 8'h08, 8'h00, 8'h86, 3'h2);
      tcase(7, 8'h00, 8'h00, 8'h87, 3'h2);
      // Level 3 in service holds off level 7 but not level 0
      wr(4'h1, 8'h20);
      @(posedge clk);
      src <= 18'h10;
      cic_core_model_inst.ack(1);
      src <= 18'h810;
      settle();
      chk({7'h00, coreIntr}, 8'h00);
      wr(4'h7, 8'hFF);
      rd(4'h7, 8'h08);
      src <= 18'h811;
      settle();
      chk({7'h00, coreIntr}, 8'h01);
      src <= 18'h0;
      wr(4'h4, 8'h03);
      rd(4'h7, 8'h00);
      // Outside slave on input 4: code on address lines, bus left alone
      wr(4'hB, 8'h14);
      wr(4'h0, 8'h80);
      a = cic_core_model_inst.oeCount;
      src <= 18'h8;
      settle();
      chk({7'h00, upperAddrOe}, 8'h01);
      cic_core_model_inst.ack(1);
      chk({5'h00, cic_core_model_inst.midAddr}, 8'h04);
      chk(cic_core_model_inst.oeCount[7:0], a[7:0]);
      chk({5'h00, upperAddrLines}, 8'h07);
      src <= 18'h0;
      wr(4'h4, 8'h07);
      wr(4'hB, 8'h04);
      // Slow acknowledge of a slave source; events masked, unmasked, cleared
      wr(4'h9, 8'h07);
      rd(4'h9, 8'h00);
      src <= 18'h2;
      cic_core_model_inst.ack(2);
      chk(cic_core_model_inst.lastVec, 8'h82);
      chk({5'h00, cic_core_model_inst.lastCas}, 8'h02);
      chk({5'h00, cic_core_model_inst.midCas}, 8'h07);
      rd(4'h8, 8'h04);
      rd(4'h9, 8'h03);
      chk({7'h00, irq}, 8'h00);
      wr(4'hA, 8'h03);
      settle();
      chk({7'h00, irq}, 8'h01);
      wr(4'h9, 8'h03);
      settle();
      chk({7'h00, irq}, 8'h00);
      // Higher slave source re-enters through master input 2 at equal level
      src <= 18'h22;
      settle();
      chk({7'h00, coreIntr}, 8'h01);
      src <= 18'h0;
      wr(4'h4, 8'h07);
      // Acknowledge with no request: spurious event and lowest-level vector
      cic_core_model_inst.ack(1);
      chk(cic_core_model_inst.lastVec, 8'h47);
      rd(4'h9, 8'h07);
      chk(cic_core_model_inst.waitOut[7:0], 8'h01);
      chk(cic_core_model_inst.oeEarly[7:0], 8'h00);
      final_report();
   end
endmodule // cic_top_tb
`default_nettype wire
